// ===== rtl/shp_fifo.sv
// parameterised valid/ready fifo
module shp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // fill side
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   // drain side
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   localparam int PW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << PW) != DEPTH) $error("depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0] wp_ff;
   logic [PW:0] rp_ff;
   logic push;
   logic pop;
   assign o_ready = (wp_ff - rp_ff) != (PW+1)'(DEPTH);
   assign o_valid = wp_ff != rp_ff;
   assign o_data = mem[rp_ff[PW-1:0]];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem[wp_ff[PW-1:0]] <= i_data;
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         wp_ff <= '0;
         rp_ff <= '0;
      end else begin
         if (push) wp_ff <= wp_ff + 1'b1;
         if (pop) rp_ff <= rp_ff + 1'b1;
      end
   end
   a_fifo_no_over: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (wp_ff - rp_ff) <= (PW+1)'(DEPTH)) else $error("fifo overfilled");
endmodule

// ===== rtl/shp_host_port.sv
// sram-like 16-bit host port with fifo paths, wake and interrupt
module shp_host_port
   import shp_pkg::*;
#(
   parameter int NSRC = SHP_NSRC
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // host pins
   input wire logic i_chip_select_n,
   input wire logic i_read_strobe_n,
   input wire logic i_write_strobe_n,
   input wire logic i_fifo_sel,
   input wire logic [SHP_AW-1:0] i_addr,
   input wire logic [15:0] i_data,
   output logic [15:0] o_data,
   output logic o_data_oe,
   output logic o_irq,
   output logic o_irq_oe,
   // tx data toward the mac
   output logic o_tx_valid,
   input wire logic i_tx_ready,
   output logic [31:0] o_tx_data,
   // rx data from the mac
   input wire logic i_rx_valid,
   output logic o_rx_ready,
   input wire logic [31:0] i_rx_data,
   // power and events
   input wire logic i_sleep_req,
   input wire logic [NSRC-1:0] i_irq_src,
   output logic o_asleep,
   output logic o_wake_ev
);
   initial begin
      if (NSRC < 1 || NSRC > 8) $error("NSRC must be 1..8");
   end
   // ************************************************
   // access detection
   // ************************************************
   shp_acc_type acc;
   shp_acc_type acc_d_ff;
   logic is_fifo;
   logic is_tx;
   logic rd_start;
   logic wr_end;
   logic [SHP_AW-1:0] wr_addr_ff;
   logic [15:0] wr_data_ff;
   logic wr_fifo_ff;
   always_comb begin
      acc = SHP_IDLE;
      if (!i_chip_select_n) begin
         if (!i_read_strobe_n) acc = SHP_RD;
         else if (!i_write_strobe_n) acc = SHP_WR;
      end
   end
   // fifo_sel forces the fifo window; upper address bits are dropped there
   assign is_fifo = i_fifo_sel || (i_addr < SHP_CSR_BASE);
   assign is_tx = i_fifo_sel ? i_addr[SHP_FSEL_TX_BIT] : (i_addr[4:3] == SHP_FIFO_PORT_TX);
   assign rd_start = (acc == SHP_RD) && (acc_d_ff != SHP_RD);
   // write commits on strobe release so data has settled
   assign wr_end = (acc_d_ff == SHP_WR) && (acc != SHP_WR);
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         acc_d_ff <= SHP_IDLE;
         wr_addr_ff <= '0;
         wr_data_ff <= '0;
         wr_fifo_ff <= 1'b0;
      end else begin
         acc_d_ff <= acc;
         if (acc == SHP_WR) begin
            wr_addr_ff <= i_addr;
            wr_data_ff <= i_data;
            wr_fifo_ff <= is_fifo && is_tx;
         end
      end
   end
   // ************************************************
   // power state and read-before-write gate
   // ************************************************
   logic asleep_ff;
   logic armed_ff;
   logic wake_ev_ff;
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         asleep_ff <= 1'b0;
         wake_ev_ff <= 1'b0;
      end else begin
         wake_ev_ff <= 1'b0;
         if (asleep_ff && acc == SHP_WR) begin
            asleep_ff <= 1'b0;
            wake_ev_ff <= 1'b1;
         end else if (i_sleep_req) begin
            asleep_ff <= 1'b1;
         end
      end
   end
   // writes are dropped until one read after reset or wake
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         armed_ff <= 1'b0;
      end else if (asleep_ff || wake_ev_ff) begin
         armed_ff <= 1'b0;
      end else if (rd_start) begin
         armed_ff <= 1'b1;
      end
   end
   logic wr_ok;
   assign wr_ok = wr_end && armed_ff && !asleep_ff;
   // ************************************************
   // tx path: 16 to 32 pairing, low half first
   // ************************************************
   logic [15:0] tx_lo_ff;
   logic tx_half_ff;
   logic tx_push;
   logic tx_fill_rdy;
   assign tx_push = wr_ok && wr_fifo_ff && tx_half_ff;
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         tx_lo_ff <= '0;
         tx_half_ff <= 1'b0;
      end else if (wr_ok && wr_fifo_ff && (tx_half_ff ? tx_fill_rdy : 1'b1)) begin
         tx_lo_ff <= wr_data_ff;
         tx_half_ff <= !tx_half_ff;
      end
   end
   logic tx_v;
   logic [31:0] tx_d;
   shp_fifo #(.WIDTH(32), .DEPTH(SHP_FIFO_DEPTH)) u_tx_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_valid(tx_push),
      .o_ready(tx_fill_rdy),
      .i_data({wr_data_ff, tx_lo_ff}),
      .o_valid(tx_v),
      // pop exactly when the output stage loads, so no word is sent twice
      .i_ready(!o_tx_valid),
      .o_data(tx_d)
   );
   // output stage register keeps outputs flop-driven
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_tx_valid <= 1'b0;
         o_tx_data <= '0;
      end else if (!o_tx_valid || i_tx_ready) begin
         o_tx_valid <= tx_v && !o_tx_valid;
         o_tx_data <= tx_d;
      end
   end
   // ************************************************
   // rx path: 32 to 16 splitting, low half first
   // ************************************************
   logic rx_v;
   logic [31:0] rx_d;
   logic rx_half_ff;
   logic rx_pop;
   logic rx_rd;
   assign rx_rd = rd_start && is_fifo && !is_tx && !asleep_ff;
   assign rx_pop = rx_rd && rx_half_ff && rx_v;
   shp_fifo #(.WIDTH(32), .DEPTH(SHP_FIFO_DEPTH)) u_rx_fifo (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_valid(i_rx_valid),
      .o_ready(o_rx_ready),
      .i_data(i_rx_data),
      .o_valid(rx_v),
      .i_ready(rx_pop),
      .o_data(rx_d)
   );
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rx_half_ff <= 1'b0;
      end else if (rx_rd && rx_v) begin
         rx_half_ff <= !rx_half_ff;
      end
   end
   // ************************************************
   // configuration register and read data
   // ************************************************
   logic [15:0] irq_cfg_ff;
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         irq_cfg_ff <= SHP_IRQ_CFG_RST;
      end else if (wr_ok && !wr_fifo_ff && wr_addr_ff == SHP_ADDR_IRQ_CFG) begin
         irq_cfg_ff <= wr_data_ff;
      end
   end
   function automatic logic [15:0] rd_mux(input logic [SHP_AW-1:0] a, input logic f,
                                          input logic h, input logic [31:0] rx);
      logic [15:0] r;
      r = 16'h0000;
      if (f) r = h ? rx[31:16] : rx[15:0];
      else if (a == SHP_ADDR_BYTE_TEST) r = SHP_BYTE_TEST_VAL[15:0];
      else if (a == SHP_ADDR_BYTE_TEST + 7'h01) r = SHP_BYTE_TEST_VAL[31:16];
      else if (a == SHP_ADDR_IRQ_CFG) r = irq_cfg_ff;
      else if (a == SHP_ADDR_PWR) r = {15'h0000, asleep_ff};
      return r;
   endfunction
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_data <= '0;
         o_data_oe <= 1'b0;
      end else begin
         o_data_oe <= (acc == SHP_RD);
         if (rd_start) begin
            o_data <= rd_mux(i_addr, is_fifo && !is_tx, rx_half_ff, rx_d);
         end
      end
   end
   // ************************************************
   // interrupt pin
   // ************************************************
   logic irq_act;
   assign irq_act = |(i_irq_src & irq_cfg_ff[SHP_IRQ_EN_LSB +: NSRC]);
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_irq <= 1'b0;
         o_irq_oe <= 1'b0;
         o_asleep <= 1'b0;
         o_wake_ev <= 1'b0;
      end else begin
         o_asleep <= asleep_ff;
         o_wake_ev <= wake_ev_ff;
         if (irq_cfg_ff[SHP_IRQ_OD_BIT]) begin
            // open drain: pull the line only when active
            o_irq <= 1'b0;
            o_irq_oe <= irq_act;
         end else begin
            o_irq <= irq_act ~^ irq_cfg_ff[SHP_IRQ_POL_BIT];
            o_irq_oe <= 1'b1;
         end
      end
   end
   // ************************************************
   // checks
   // ************************************************
   sequence s_host_wr;
      !i_chip_select_n && !i_write_strobe_n && i_read_strobe_n;
   endsequence
   a_wake_on_write: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      asleep_ff ##0 s_host_wr ##0 !i_sleep_req |=> !asleep_ff && wake_ev_ff)
      else $error("write did not wake");
   a_bus_read_only: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_data_oe |-> $past(!i_chip_select_n && !i_read_strobe_n))
      else $error("bus driven outside read");
   a_cs_gates_read: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      i_chip_select_n |=> !o_data_oe) else $error("read without select");
   a_read_drives: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (!i_chip_select_n && !i_read_strobe_n) |=> o_data_oe) else $error("read not served");
   a_write_gated: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !armed_ff |-> !tx_push) else $error("write before read took effect");
   a_write_seen: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      s_host_wr |=> acc_d_ff == SHP_WR) else $error("write not seen");
   a_irq_od: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      irq_cfg_ff[SHP_IRQ_OD_BIT] |=> !o_irq) else $error("open drain drove high");
   a_pair_push: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      tx_push |-> tx_half_ff) else $error("push on odd half");
   a_fifo_sel_map: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      i_fifo_sel |-> is_fifo) else $error("fifo select not honoured");
endmodule

// ===== rtl/shp_pkg.sv
// package of constants for the sram-like host port
package shp_pkg;
   // ************************************************
   // address map
   // ************************************************
   localparam int SHP_AW = 7;
   localparam logic [1:0] SHP_FIFO_PORT_RX = 2'h0;
   localparam logic [1:0] SHP_FIFO_PORT_TX = 2'h1;
   // with fifo select only word address bits 1:0 survive; bit 1 picks tx over rx
   localparam int SHP_FSEL_TX_BIT = 1;
   localparam logic [SHP_AW-1:0] SHP_CSR_BASE = 7'h28;
   localparam logic [SHP_AW-1:0] SHP_ADDR_BYTE_TEST = 7'h32;
   localparam logic [SHP_AW-1:0] SHP_ADDR_IRQ_CFG = 7'h2A;
   localparam logic [SHP_AW-1:0] SHP_ADDR_PWR = 7'h2C;
   localparam logic [31:0] SHP_BYTE_TEST_VAL = 32'h87654321;
   // ************************************************
   // irq config fields
   // ************************************************
   localparam int SHP_IRQ_POL_BIT = 4;
   localparam int SHP_IRQ_OD_BIT = 0;
   localparam int SHP_IRQ_EN_LSB = 8;
   localparam int SHP_NSRC = 4;
   localparam logic [15:0] SHP_IRQ_CFG_RST = 16'h0000;
   localparam int SHP_FIFO_DEPTH = 8;
   typedef enum logic [1:0] {SHP_IDLE, SHP_RD, SHP_WR} shp_acc_type;
endpackage

// ===== testbench/shp_host_model.sv
// host cpu model driving the sram-like host port pins
module shp_host_model
   import shp_pkg::*;
(
   // clock
   input wire logic i_clk_sys,
   // host pins
   output logic o_chip_select_n,
   output logic o_read_strobe_n,
   output logic o_write_strobe_n,
   output logic o_fifo_sel,
   output logic [SHP_AW-1:0] o_addr,
   output logic [15:0] o_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_chip_select_n = 1'b1;
      o_read_strobe_n = 1'b1;
      o_write_strobe_n = 1'b1;
      o_fifo_sel = 1'b0;
      o_addr = '0;
      o_data = 16'h5A5A;
   end
   // strobe held over two edges, then idle; a released bus shows the inverse of its last value
   task automatic cycle(input logic rd, input logic cs_n, input logic fs,
      input logic [SHP_AW-1:0] a, input logic [15:0] d);
      @(negedge i_clk_sys);
      o_chip_select_n = cs_n;
      o_read_strobe_n = !rd;
      o_write_strobe_n = rd;
      o_fifo_sel = fs;
      o_addr = a;
      o_data = rd ? ~o_data : d;
      repeat (2) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      o_chip_select_n = 1'b1;
      o_read_strobe_n = 1'b1;
      o_write_strobe_n = 1'b1;
      o_addr = ~a;
      o_data = ~o_data;
      repeat (2) @(posedge i_clk_sys);
   endtask
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the sram-like host port
module testbench
   import shp_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys, i_rstn, csn, rdn, wrn, fs, oe, irq, irq_oe, txv, txr, rxv, rxr, slp;
   logic asleep, wake, taken;
   logic [SHP_AW-1:0] addr;
   logic [15:0] hd, od, seed;
   logic [31:0] txd, rxd, w;
   logic [SHP_NSRC-1:0] src;
   logic [15:0] rdq[$];
   logic [31:0] txq[$], rxq[$];
   int n_fail = 0, n_compared = 0, n_wake = 0;
   shp_host_model host_i (.i_clk_sys(i_clk_sys), .o_chip_select_n(csn),
      .o_read_strobe_n(rdn), .o_write_strobe_n(wrn), .o_fifo_sel(fs), .o_addr(addr),
      .o_data(hd));
   shp_host_port shp_host_port_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
      .i_chip_select_n(csn), .i_read_strobe_n(rdn), .i_write_strobe_n(wrn),
      .i_fifo_sel(fs), .i_addr(addr), .i_data(hd), .o_data(od), .o_data_oe(oe),
      .o_irq(irq), .o_irq_oe(irq_oe), .o_tx_valid(txv), .i_tx_ready(txr),
      .o_tx_data(txd), .i_rx_valid(rxv), .o_rx_ready(rxr), .i_rx_data(rxd),
      .i_sleep_req(slp), .i_irq_src(src), .o_asleep(asleep), .o_wake_ev(wake));
   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_fail, n_compared);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   function automatic logic [15:0] lfsr16(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic rnd32(output logic [31:0] v);
      seed = lfsr16(seed);
      v[15:0] = seed;
      seed = lfsr16(seed);
      v[31:16] = seed;
   endtask
   task automatic hrd(input logic [SHP_AW-1:0] a, input logic f, input logic [15:0] exp);
      rdq.push_back(exp);
      host_i.cycle(1'b1, 1'b0, f, a, 16'h0000);
   endtask
   task automatic hwr(input logic [SHP_AW-1:0] a, input logic f, input logic [15:0] d);
      host_i.cycle(1'b0, 1'b0, f, a, d);
   endtask
   task automatic irq_case(input logic [SHP_NSRC-1:0] s, input logic [1:0] exp);
      @(negedge i_clk_sys);
      src = s;
      repeat (4) @(negedge i_clk_sys);
      check({irq, irq_oe}, exp);
   endtask
   // ************
   // monitors
   // ************
   always @(negedge i_clk_sys) begin
      if (oe === 1'b1 && taken !== 1'b1) begin
         taken = 1'b1;
         if (rdq.size() == 0) check(oe, 1'b0);
         else check(od, rdq.pop_front());
      end else if (oe !== 1'b1) begin
         taken = 1'b0;
      end
   end
   always @(posedge i_clk_sys) begin
      if (txv === 1'b1 && txr === 1'b1) check(txd, txq.pop_front());
      if (wake === 1'b1) n_wake++;
   end
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      n_fail++;
      $display("watchdog expired");
      complete_run();
   end
   // ************
   // main sequence
   // ************
   initial begin
      seed = 16'h8F2B;
      i_rstn = 1'b0;
      txr = 1'b0;
      rxv = 1'b0;
      rxd = '0;
      slp = 1'b0;
      src = '0;
      taken = 1'b0;
      repeat (5) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      i_rstn = 1'b1;
      check({oe, irq_oe, irq, txv, asleep, wake}, 6'h00);
      hwr(SHP_ADDR_IRQ_CFG, 1'b0, 16'h0110);
      hrd(SHP_ADDR_IRQ_CFG, 1'b0, SHP_IRQ_CFG_RST);
      hwr(SHP_ADDR_IRQ_CFG, 1'b0, 16'h0110);
      hrd(SHP_ADDR_IRQ_CFG, 1'b0, 16'h0110);
      host_i.cycle(1'b0, 1'b1, 1'b0, SHP_ADDR_IRQ_CFG, 16'h0000);
      host_i.cycle(1'b1, 1'b1, 1'b0, SHP_ADDR_IRQ_CFG, 16'h0000);
      hrd(SHP_ADDR_IRQ_CFG, 1'b0, 16'h0110);
      irq_case(4'h1, 2'b11);
      irq_case(4'h2, 2'b01);
      irq_case(4'h0, 2'b01);
      hwr(SHP_ADDR_IRQ_CFG, 1'b0, 16'h0100);
      irq_case(4'h1, 2'b01);
      irq_case(4'h0, 2'b11);
      hwr(SHP_ADDR_IRQ_CFG, 1'b0, 16'h0101);
      irq_case(4'h1, 2'b01);
      irq_case(4'h0, 2'b00);
      hrd(SHP_ADDR_BYTE_TEST, 1'b0, SHP_BYTE_TEST_VAL[15:0]);
      hrd(SHP_ADDR_BYTE_TEST + 7'h01, 1'b0, SHP_BYTE_TEST_VAL[31:16]);
      // tx words pile up while the mac side stalls, then drain with random stalls
      for (int i = 0; i < SHP_FIFO_DEPTH; i++) begin
         rnd32(w);
         txq.push_back(w);
         hwr(7'h08, 1'b0, w[15:0]);
         hwr(7'h08, 1'b0, w[31:16]);
      end
      for (int i = 0; i < 200 && txq.size() > 0; i++) begin
         @(negedge i_clk_sys);
         txr = seed[3];
         seed = lfsr16(seed);
      end
      check(txq.size(), 32'h0);
      // rx fifo filled until it refuses, then read out through the fifo window
      for (int i = 0; i < 12; i++) begin
         @(negedge i_clk_sys);
         rxv = 1'b0;
         if (rxr === 1'b1) begin
            rnd32(w);
            rxv = 1'b1;
            rxd = w;
            rxq.push_back(w);
         end
      end
      @(negedge i_clk_sys);
      rxv = 1'b0;
      check(rxr, 1'b0);
      check(rxq.size(), SHP_FIFO_DEPTH);
      for (int i = 0; i < SHP_FIFO_DEPTH; i++) begin
         w = rxq.pop_front();
         hrd(7'h7C, 1'b1, w[15:0]);
         hrd(7'h7C, 1'b1, w[31:16]);
      end
      check(rxr, 1'b1);
      @(negedge i_clk_sys);
      slp = 1'b1;
      for (int i = 0; i < 20 && asleep !== 1'b1; i++) @(negedge i_clk_sys);
      slp = 1'b0;
      check(asleep, 1'b1);
      check(n_wake, 32'h0);
      hwr(SHP_ADDR_BYTE_TEST, 1'b0, 16'h0000);
      repeat (2) @(negedge i_clk_sys);
      check(asleep, 1'b0);
      check(n_wake, 32'h1);
      hwr(SHP_ADDR_IRQ_CFG, 1'b0, 16'h0000);
      hrd(SHP_ADDR_IRQ_CFG, 1'b0, 16'h0101);
      hwr(SHP_ADDR_IRQ_CFG, 1'b0, 16'h0000);
      hrd(SHP_ADDR_IRQ_CFG, 1'b0, 16'h0000);
      repeat (4) @(negedge i_clk_sys);
      check(rdq.size(), 32'h0);
      complete_run();
   end
endmodule
